// ===== tb_usart_baud_and_async_receiver.sv
// Testbench of the baud generator and receiver front end.
`timescale 1ns/100ps
module tb_usart_baud_and_async_receiver;
	import ubr_pkg::*;
	logic        sys_clk   = 1'b0;
	logic        rst_n     = 1'b0;
	logic [3:0]  reg_addr  = 4'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr    = 1'b0;
	logic        reg_rd    = 1'b0;
	logic [31:0] reg_rdata;
	logic [31:0] rv;
	logic        sck_out, sck_oe, baud_tick, rxd, sck;
	int          miscompares = 0, checks_done = 0, cycles = 0, seed = 5907;
	logic [7:0]  ch, ch2;
	logic [15:0] dv;
	always #2 sys_clk = ~sys_clk;
	ubr_core u_ubr_core (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.sck_in(sck_oe ? sck_out : sck), .sck_out(sck_out), .sck_oe(sck_oe),
		.rxd_in(rxd), .baud_tick(baud_tick));
	ubr_remote u_ubr_remote (.sys_clk(sys_clk), .rxd(rxd), .sck(sck));
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd
	task automatic count(input int cyc, output int k);
		k = 0;
		repeat (cyc) begin
			@(posedge sys_clk);
			#1 if (baud_tick === 1'b1) k++;
		end
	endtask : count
	// The first tick after a change may be irregular, so the third gap is kept.
	task automatic period(output int p);
		for (int j = 0; j < 3; j++) begin
			p = 0;
			do begin
				@(posedge sys_clk);
				#1 p++;
			end while (baud_tick !== 1'b1 && p < 3000);
		end
	endtask : period
	function automatic int exp_period(input logic [31:0] m, input int d);
		return d * (m[UBR_MODE_SYNC] ? 1 : 16) * (m[UBR_MODE_SRC_LO] ? 8 : 1);
	endfunction : exp_period
	function automatic logic [8:0] exp_char(input logic [7:0] d, input logic [31:0] m);
		int n;
		n = 5 + m[UBR_MODE_LEN_HI:UBR_MODE_LEN_LO] + m[UBR_MODE_PAR];
		return {1'b0, d} & 9'((1 << n) - 1);
	endfunction : exp_char
	task automatic stop_test;
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : stop_test
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 40000) begin
			miscompares++;
			stop_test();
		end
	end
	initial begin
		int i, p, k;
		logic [31:0] m;
		repeat (8) @(posedge sys_clk);
		rst_n <= 1'b1;
		wr(4'hF, 32'hFFFF_FFFF);
		rd(4'hF, rv);
		for (i = 0; i < 4; i++) begin
			m  = {24'h0, i[1], 2'h0, i[0], 4'h3};
			dv = 16'h2 + 16'($random(seed) & 3);
			wr(UBR_ADDR_DIV, {16'h0, dv});
			wr(UBR_ADDR_MODE, m);
			period(p);
			check(p, exp_period(m, dv));
		end
		wr(UBR_ADDR_DIV, 32'h0);
		count(300, k);
		check(k, 0);
		$display("baud periods done");
		for (i = 0; i < 4; i++) begin
			wr(UBR_ADDR_MODE, i << 5);
			repeat (4) @(posedge sys_clk);
			#1 check({31'h0, sck_oe}, i == 2);
		end
		wr(UBR_ADDR_MODE, 32'hA3);
		fork
			u_ubr_remote.clocks(6, 4);
			count(80, k);
		join
		check(k, 6);
		$display("clock pin done");
		ch  = 8'($random(seed));
		ch2 = 8'($random(seed));
		wr(UBR_ADDR_DIV, 32'h2);
		wr(UBR_ADDR_MODE, 32'h3);
		u_ubr_remote.glitch(14);
		u_ubr_remote.send(ch, 32);
		repeat (10) @(posedge sys_clk);
		rd(UBR_ADDR_STATUS, rv);
		check(rv & 32'h3, 32'h1);
		rd(UBR_ADDR_HOLD, rv);
		check(rv & 32'hFF, {24'h0, ch});
		rd(UBR_ADDR_STATUS, rv);
		check(rv & 32'h3, 32'h0);
		u_ubr_remote.send(ch2, 32);
		u_ubr_remote.send(ch, 32);
		repeat (10) @(posedge sys_clk);
		rd(UBR_ADDR_STATUS, rv);
		check(rv & 32'h3, 32'h3);
		rd(UBR_ADDR_HOLD, rv);
		check(rv & 32'hFF, {24'h0, ch});
		wr(UBR_ADDR_DIV, 32'h4);
		wr(UBR_ADDR_MODE, 32'h182);
		u_ubr_remote.send(ch2, 4);
		repeat (10) @(posedge sys_clk);
		rd(UBR_ADDR_HOLD, rv);
		check(rv, {23'h0, exp_char(ch2, 32'h182)});
		$display("receive done");
		stop_test();
	end
endmodule : tb_usart_baud_and_async_receiver

// ===== ubr_core.sv
// Baud rate generator and receiver front end of one serial channel.
`timescale 1ns/100ps
module ubr_core
	import ubr_pkg::*;
(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	// Register port
	input  wire logic [3:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	// Serial pins
	input  wire logic        sck_in,
	output logic             sck_out,
	output logic             sck_oe,
	input  wire logic        rxd_in,
	// Baud clock to the transmitter side
	output logic             baud_tick
);
	import ubr_pkg::*;

	// ==========================================================
	// Registers
	// ==========================================================
	logic [31:0] channel_mode_register;
	logic [15:0] baud_divisor_register;
	logic [8:0]  receive_holding_register;
	logic        receive_ready_flag;
	logic        overrun_flag;

	logic [1:0]  clock_source_select;
	logic        clock_output_enable;
	logic        sync_mode;
	logic [15:0] baud_divisor_value;
	assign clock_source_select = channel_mode_register[UBR_MODE_SRC_HI:UBR_MODE_SRC_LO];
	assign clock_output_enable = channel_mode_register[UBR_MODE_CLOCK_OUTPUT_ENABLE];
	assign sync_mode           = channel_mode_register[UBR_MODE_SYNC];
	assign baud_divisor_value  = baud_divisor_register;

	logic       char_done;
	logic [8:0] char_data;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			channel_mode_register <= UBR_MODE_RESET;
			baud_divisor_register <= UBR_DIV_RESET;
		end else if (reg_wr) begin
			if (reg_addr == UBR_ADDR_MODE) begin
				channel_mode_register <= reg_wdata;
			end
			if (reg_addr == UBR_ADDR_DIV) begin
				baud_divisor_register <= reg_wdata[15:0];
			end
		end
	end

	// Reading the holding register clears ready; a new character wins over that clear.
	logic hold_read;
	assign hold_read = reg_rd && (reg_addr == UBR_ADDR_HOLD);

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			receive_holding_register <= '0;
			receive_ready_flag       <= 1'b0;
			overrun_flag             <= 1'b0;
		end else begin
			if (char_done) begin
				receive_holding_register <= char_data;
				receive_ready_flag       <= 1'b1;
				if (receive_ready_flag && !hold_read) begin
					overrun_flag <= 1'b1;
				end
			end else if (hold_read) begin
				receive_ready_flag <= 1'b0;
			end
			// Status read clears overrun unless a new overrun lands now.
			if (reg_rd && reg_addr == UBR_ADDR_STATUS &&
				!(char_done && receive_ready_flag && !hold_read)) begin
				overrun_flag <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			case (reg_addr)
				UBR_ADDR_MODE:   reg_rdata <= channel_mode_register;
				UBR_ADDR_DIV:    reg_rdata <= {16'h0000, baud_divisor_register};
				UBR_ADDR_HOLD:   reg_rdata <= {23'h000000, receive_holding_register};
				UBR_ADDR_STATUS: reg_rdata <= {30'h00000000, overrun_flag,
					receive_ready_flag};
				default:         reg_rdata <= '0;
			endcase
		end else begin
			reg_rdata <= '0;
		end
	end

	// ==========================================================
	// Pin synchronisers
	// ==========================================================
	logic sck_level;
	logic sck_rise;
	logic rxd_level;

	ubr_sync u_sck_sync (
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.async_in (sck_in),
		.level    (sck_level),
		.rise     (sck_rise)
	);

	ubr_sync u_rxd_sync (
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.async_in (rxd_in),
		.level    (rxd_level),
		.rise     ()
	);

	// ==========================================================
	// Baud rate generator
	// ==========================================================
	// The source is an enable: every master cycle, one in eight, or each
	// synchronised rising edge of the pin clock. The pin path only works
	// while the far side keeps its clock slow enough to be sampled.
	logic [2:0]  prescale;
	logic        src_tick;
	logic        ext_sel;
	logic [15:0] div_count;
	logic [3:0]  over_count;
	logic        sample_tick;
	logic        bit_tick;
	logic        sck_drive;

	assign ext_sel = clock_source_select[1];

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			prescale <= '0;
		end else begin
			prescale <= prescale + 3'h1;
		end
	end

	always_comb begin
		if (ext_sel) begin
			src_tick = sck_rise;
		end else if (clock_source_select[0] == UBR_SRC_MCK8[0]) begin
			src_tick = (prescale == UBR_PRESCALE_LAST);
		end else begin
			src_tick = 1'b1;
		end
	end

	// Divisor stage: one pulse per divisor source ticks, none when zero.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_count   <= '0;
			sample_tick <= 1'b0;
		end else begin
			sample_tick <= 1'b0;
			if (baud_divisor_value == 16'h0000) begin
				div_count <= '0;
			end else if (src_tick) begin
				if (div_count >= baud_divisor_value - 16'h0001) begin
					div_count   <= '0;
					sample_tick <= 1'b1;
				end else begin
					div_count <= div_count + 16'h0001;
				end
			end
		end
	end

	// Sixteen-fold stage for asynchronous mode only.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			over_count <= '0;
		end else if (sync_mode || baud_divisor_value == 16'h0000) begin
			over_count <= '0;
		end else if (sample_tick) begin
			over_count <= over_count + 4'h1;
		end
	end

	always_comb begin
		if (sync_mode && ext_sel) begin
			bit_tick = sck_rise;
		end else if (sync_mode) begin
			bit_tick = sample_tick;
		end else begin
			bit_tick = sample_tick && (over_count == UBR_OVERSAMPLE_LAST);
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			baud_tick <= 1'b0;
		end else begin
			baud_tick <= bit_tick && (baud_divisor_value != 16'h0000 || (sync_mode && ext_sel));
		end
	end

	// Clock output: toggle on each bit clock tick, driven only for internal sources.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sck_drive <= 1'b0;
			sck_out   <= 1'b0;
			sck_oe    <= 1'b0;
		end else begin
			if (baud_tick) begin
				sck_drive <= ~sck_drive;
			end
			sck_out <= sck_drive;
			sck_oe  <= !ext_sel && clock_output_enable;
		end
	end

	// ==========================================================
	// Receiver
	// ==========================================================
	// Character length is five plus the length field; parity adds one.
	ubr_rx_state_t state;
	logic [4:0]    phase;
	logic [3:0]    bit_index;
	logic [3:0]    bits_total;
	logic [9:0]    shift;
	logic          rx_tick;

	assign bits_total = UBR_BASE_BITS +
		{2'b00, channel_mode_register[UBR_MODE_LEN_HI:UBR_MODE_LEN_LO]} +
		{3'b000, channel_mode_register[UBR_MODE_PAR]};
	assign rx_tick = sync_mode ? (sync_mode && ext_sel ? sck_rise : sample_tick)
		: (sample_tick && baud_divisor_value != 16'h0000);

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state     <= UBR_HUNT;
			phase     <= '0;
			bit_index <= '0;
			shift     <= '0;
			char_done <= 1'b0;
			char_data <= '0;
		end else begin
			char_done <= 1'b0;
			case (state)
				UBR_HUNT: begin
					phase     <= '0;
					bit_index <= '0;
					if (rx_tick && !rxd_level) begin
						state <= sync_mode ? UBR_SHIFT : UBR_QUAL;
						phase <= 5'h01;
					end
				end
				UBR_QUAL: if (rx_tick) begin
					if (rxd_level) begin
						state <= UBR_HUNT;
						phase <= '0;
					end else if (phase == UBR_START_QUAL) begin
						state <= UBR_SHIFT;
						phase <= phase + 5'h01;
					end else begin
						phase <= phase + 5'h01;
					end
				end
				UBR_SHIFT: if (rx_tick) begin
					// Async: first sample at 24, then every 16.
					if (sync_mode || phase == UBR_FIRST_WAIT + (UBR_BIT_CYCLES >> 1) ||
						(bit_index != 4'h0 && phase == UBR_BIT_CYCLES - 5'h01)) begin
						phase     <= '0;
						shift     <= {rxd_level, shift[9:1]};
						bit_index <= bit_index + 4'h1;
						if (bit_index == bits_total) begin
							state <= UBR_DONE;
						end
					end else begin
						phase <= phase + 5'h01;
					end
				end
				UBR_DONE: begin
					char_done <= 1'b1;
					// The stop sample sits in the top bit, so the character ends just below it.
					char_data <= 9'(shift[8:0] >> (4'h9 - bits_total));
					state     <= UBR_HUNT;
				end
				default: state <= UBR_HUNT;
			endcase
		end
	end
endmodule : ubr_core

// ===== ubr_core_asserts.sv
// Port checker of the baud generator and receiver front end.
`timescale 1ns/100ps
module ubr_core_asserts
	import ubr_pkg::*;
(
	// Clock and reset
	input wire logic        sys_clk,
	input wire logic        rst_n,
	// Register port
	input wire logic [3:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	// Pins and tick
	input wire logic        sck_in,
	input wire logic        sck_out,
	input wire logic        sck_oe,
	input wire logic        rxd_in,
	input wire logic        baud_tick
);
	logic [31:0] mode;
	logic [15:0] div;
	logic [23:0] gap;
	logic [3:0]  since_cfg;
	logic [3:0]  since_rise;
	logic        armed;
	logic        sck_q;
	logic        cfg_wr;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	assign cfg_wr = reg_wr && reg_addr <= UBR_ADDR_DIV;
	// Settings mirror; checks wait until a setting has stood for 15 cycles.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode      <= UBR_MODE_RESET;
			div       <= UBR_DIV_RESET;
			since_cfg <= 4'h0;
		end else begin
			if (reg_wr && reg_addr == UBR_ADDR_MODE) mode <= reg_wdata;
			if (reg_wr && reg_addr == UBR_ADDR_DIV) div <= reg_wdata[15:0];
			since_cfg <= cfg_wr ? 4'h0 : since_cfg + {3'h0, since_cfg != 4'hF};
		end
	end
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			gap        <= 24'h0;
			armed      <= 1'b0;
			sck_q      <= 1'b0;
			since_rise <= 4'hF;
		end else begin
			gap        <= baud_tick ? 24'h1 : gap + 24'h1;
			armed      <= cfg_wr ? 1'b0 : armed | (baud_tick && since_cfg == 4'hF);
			sck_q      <= sck_in;
			since_rise <= (sck_in && !sck_q) ? 4'h0 : since_rise + {3'h0, since_rise != 4'hF};
		end
	end
	a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data not zero outside a read answer");
	a_unmapped_read_zero: assert property ($past(reg_rd) && $past(reg_addr) > UBR_ADDR_STATUS
		|-> reg_rdata == 32'h0) else $error("unmapped read not zero");
	a_pin_drive_mode: assert property (since_cfg == 4'hF |->
		sck_oe == (!mode[UBR_MODE_SRC_HI] && mode[UBR_MODE_CLOCK_OUTPUT_ENABLE])) else $error("clock pin drive wrong");
	a_zero_div_quiet: assert property (div == 16'h0 && since_cfg == 4'hF
		&& !(mode[UBR_MODE_SYNC] && mode[UBR_MODE_SRC_HI]) |-> !baud_tick) else $error("tick with zero divisor");
	a_ext_tick_follows: assert property (mode[UBR_MODE_SYNC] && mode[UBR_MODE_SRC_HI]
		&& since_cfg == 4'hF && baud_tick |-> since_rise <= 4'h8) else $error("tick without pin edge");
	a_async_period: assert property (!mode[UBR_MODE_SYNC] && !mode[UBR_MODE_SRC_HI]
		&& armed && since_cfg == 4'hF && baud_tick
		|-> gap == 16 * div * (mode[UBR_MODE_SRC_LO] ? 8 : 1)) else $error("async bit period wrong");
	a_sync_period: assert property (mode[UBR_MODE_SYNC] && !mode[UBR_MODE_SRC_HI]
		&& armed && since_cfg == 4'hF && baud_tick
		|-> gap == div * (mode[UBR_MODE_SRC_LO] ? 8 : 1)) else $error("sync bit period wrong");
	a_async_tick_pulse: assert property (!mode[UBR_MODE_SYNC] && since_cfg == 4'hF
		&& baud_tick |=> !baud_tick) else $error("async tick longer than one cycle");
	a_sck_out_toggle: assert property ($past(baud_tick, 2)
		== (sck_out != $past(sck_out))) else $error("clock output not following bit clock");
endmodule : ubr_core_asserts

bind ubr_core ubr_core_asserts u_ubr_core_asserts (.sys_clk(sys_clk), .rst_n(rst_n),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .sck_in(sck_in), .sck_out(sck_out), .sck_oe(sck_oe),
	.rxd_in(rxd_in), .baud_tick(baud_tick));

// ===== ubr_pkg.sv
// Package of constants and types for the baud generator and receiver front end.
package ubr_pkg;
	// ==========================================================
	// Register map
	// ==========================================================
	localparam logic [3:0] UBR_ADDR_MODE   = 4'h0;
	localparam logic [3:0] UBR_ADDR_DIV    = 4'h1;
	localparam logic [3:0] UBR_ADDR_HOLD   = 4'h2;
	localparam logic [3:0] UBR_ADDR_STATUS = 4'h3;
	// Field positions of the channel mode register.
	localparam int UBR_MODE_SRC_LO = 4;
	localparam int UBR_MODE_SRC_HI = 5;
	localparam int UBR_MODE_CLOCK_OUTPUT_ENABLE   = 6;
	localparam int UBR_MODE_SYNC   = 7;
	localparam int UBR_MODE_PAR    = 8;
	localparam int UBR_MODE_LEN_LO = 0;
	localparam int UBR_MODE_LEN_HI = 1;
	localparam logic [31:0] UBR_MODE_RESET = 32'h0000_0000;
	localparam logic [15:0] UBR_DIV_RESET  = 16'h0000;
	// Status bits.
	localparam int UBR_ST_READY   = 0;
	localparam int UBR_ST_OVERRUN = 1;
	// ==========================================================
	// Clock source codes
	// ==========================================================
	localparam logic [1:0] UBR_SRC_MCK  = 2'h0;
	localparam logic [1:0] UBR_SRC_MCK8 = 2'h1;
	localparam logic [2:0] UBR_PRESCALE_LAST = 3'h7;
	// ==========================================================
	// Sampling timing in sampling-clock cycles
	// ==========================================================
	localparam logic [4:0] UBR_START_QUAL  = 5'h07;
	localparam logic [4:0] UBR_FIRST_WAIT  = 5'h10;
	localparam logic [4:0] UBR_BIT_CYCLES  = 5'h10;
	localparam logic [3:0] UBR_OVERSAMPLE_LAST = 4'hF;
	localparam logic [3:0] UBR_BASE_BITS   = 4'h5;
	typedef enum logic [3:0] {
		UBR_HUNT  = 4'b0001,
		UBR_QUAL  = 4'b0010,
		UBR_SHIFT = 4'b0100,
		UBR_DONE  = 4'b1000
	} ubr_rx_state_t;
endpackage : ubr_pkg

// ===== ubr_remote.sv
// Model of the remote serial device on the receive and clock pins.
`timescale 1ns/100ps
module ubr_remote (
	// Clock
	input  wire logic sys_clk,
	// Pins
	output logic      rxd,
	output logic      sck
);
	initial begin
		rxd = 1'b1;
		sck = 1'b0;
	end
	// Start, eight data bits low first, one stop bit, cyc cycles per bit.
	task automatic send(input logic [7:0] d, input int cyc);
		logic [9:0] f;
		f = {1'b1, d, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge sys_clk);
			rxd <= f[i];
			repeat (cyc - 1) @(posedge sys_clk);
		end
	endtask : send
	task automatic glitch(input int len);
		@(posedge sys_clk);
		rxd <= 1'b0;
		repeat (len) @(posedge sys_clk);
		rxd <= 1'b1;
		repeat (20) @(posedge sys_clk);
	endtask : glitch
	// Levels last several master cycles and the rate stays far below it.
	task automatic clocks(input int n, input int half);
		repeat (n) begin
			@(posedge sys_clk);
			sck <= 1'b1;
			repeat (half) @(posedge sys_clk);
			sck <= 1'b0;
			repeat (half - 1) @(posedge sys_clk);
		end
	endtask : clocks
endmodule : ubr_remote

// ===== ubr_sync.sv
// Two-stage synchroniser with edge reporting on the resynchronised level.
`timescale 1ns/100ps
module ubr_sync (
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic rst_n,
	// Signal
	input  wire logic async_in,
	output logic      level,
	output logic      rise
);
	logic stage1;
	logic stage2;
	logic stage3;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			stage1 <= 1'b1;
			stage2 <= 1'b1;
			stage3 <= 1'b1;
		end else begin
			stage1 <= async_in;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	assign level = stage2;
	assign rise  = stage2 & ~stage3;
endmodule : ubr_sync
